// File: verilog/channel_clock_divider_pair.sv
// Module: prescaler, cascaded channel sub-dividers, alignment, forcing and duty fix
`timescale 1ns/10ps
module channel_clock_divider_pair #(
    parameter int PERIOD_W = 14
) (
    // Clock and reset
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    // Register port
    input  wire logic [clkdiv_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [clkdiv_pkg::DATA_W-1:0]  wdata_i,
    input  wire logic                           wr_i,
    input  wire logic                           rd_i,
    output logic      [clkdiv_pkg::DATA_W-1:0]  rdata_o,
    // Chip-level alignment pin
    input  wire logic                           sync_i,
    // Clock levels
    output logic                                pre_clk_o,
    output logic                                sub1_clk_o,
    output logic                                chan_clk_o
);

    // Software registers
    logic [clkdiv_pkg::DATA_W-1:0] sub2_counts;
    logic [clkdiv_pkg::DATA_W-1:0] sub1_counts;
    logic [clkdiv_pkg::DATA_W-1:0] ctrl;
    logic [clkdiv_pkg::DATA_W-1:0] duty;
    logic [clkdiv_pkg::DATA_W-1:0] prescale;

    // Decoded controls
    logic       bypass1;
    logic       bypass2;
    logic       nosync;
    logic       force_high;
    logic       start1;
    logic       start2;
    logic       duty_fix_disable;
    logic [2:0] pre_code;
    logic       pre_static;
    logic [3:0] pre_ratio;

    // Alignment synchroniser
    logic sync_meta;
    logic sync_q;
    logic sync_active;

    // Prescaler
    logic [3:0] pre_cnt;
    logic       pre_tick;
    logic       pre_level;

    // Duty correction
    logic [PERIOD_W-1:0] per_cnt;
    logic [PERIOD_W-1:0] period;
    logic                period_valid;
    logic [PERIOD_W-1:0] half_period;
    logic                duty_level;
    logic                duty_on;

    // Read path
    logic [clkdiv_pkg::DATA_W-1:0] next_rdata;
    logic [clkdiv_pkg::DATA_W-1:0] status;

    subdiv_if stage1 ();
    subdiv_if stage2 ();

    assign bypass1          = ctrl[clkdiv_pkg::BIT_BYPASS1];
    assign bypass2          = ctrl[clkdiv_pkg::BIT_BYPASS2];
    assign nosync           = ctrl[clkdiv_pkg::BIT_NOSYNC];
    assign force_high       = ctrl[clkdiv_pkg::BIT_FORCE];
    assign start1           = ctrl[clkdiv_pkg::BIT_START1];
    assign start2           = ctrl[clkdiv_pkg::BIT_START2];
    assign duty_fix_disable = duty[clkdiv_pkg::BIT_DUTY_OFF];
    assign pre_code         = prescale[clkdiv_pkg::PRE_MSB:0];

    //------------------------------------------------------------------
    // Register writes, one process per register
    //------------------------------------------------------------------

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sub2_counts <= clkdiv_pkg::RST_COUNTS;
        end else if (wr_i && addr_i == clkdiv_pkg::ADDR_SUB2_COUNTS) begin
            sub2_counts <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sub1_counts <= clkdiv_pkg::RST_COUNTS;
        end else if (wr_i && addr_i == clkdiv_pkg::ADDR_SUB1_COUNTS) begin
            sub1_counts <= wdata_i;
        end
    end

    // Bits above the six control bits read back as zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= clkdiv_pkg::RST_CTRL;
        end else if (wr_i && addr_i == clkdiv_pkg::ADDR_CTRL) begin
            ctrl <= {2'h0, wdata_i[clkdiv_pkg::BIT_BYPASS2:0]};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            duty <= clkdiv_pkg::RST_DUTY;
        end else if (wr_i && addr_i == clkdiv_pkg::ADDR_DUTY) begin
            duty <= {7'h00, wdata_i[clkdiv_pkg::BIT_DUTY_OFF]};
        end
    end

    // No interlock against calibration state; software orders that itself [R14]
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prescale <= clkdiv_pkg::RST_PRESCALE;
        end else if (wr_i && addr_i == clkdiv_pkg::ADDR_PRESCALE) begin
            prescale <= {5'h00, wdata_i[clkdiv_pkg::PRE_MSB:0]};
        end
    end

    //------------------------------------------------------------------
    // Alignment signal: pin passes two flops before use
    //------------------------------------------------------------------

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_meta <= 1'b0;
            sync_q    <= 1'b0;
        end else begin
            sync_meta <= sync_i;
            sync_q    <= sync_meta;
        end
    end

    // Held dividers restart from their start polarity on release
    assign sync_active = sync_q && !nosync; // [R6]

    //------------------------------------------------------------------
    // Prescaler
    //------------------------------------------------------------------

    // Codes above the divide-by-6 code all hold the output static
    assign pre_static = (pre_code > clkdiv_pkg::PRE_DIV6); // [R13]
    assign pre_ratio  = {1'b0, pre_code} + clkdiv_pkg::PRE_BASE; // [R12]
    assign pre_tick   = !pre_static && (pre_cnt == pre_ratio - 4'h1);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_cnt <= 4'h0;
        end else if (pre_static || pre_tick || pre_cnt >= pre_ratio) begin // [R13]
            pre_cnt <= 4'h0;
        end else begin
            pre_cnt <= pre_cnt + 4'h1;
        end
    end

    // High for the first half of each period, the longer half on odd ratios
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_level <= 1'b0;
        end else if (pre_static) begin
            pre_level <= 1'b0; // [R13]
        end else begin
            pre_level <= (pre_tick || ({pre_cnt, 1'b0} < {1'b0, pre_ratio} - 5'h2)); // [R12]
        end
    end

    assign pre_clk_o = pre_level;

    //------------------------------------------------------------------
    // Cascade: prescaler -> first sub-divider -> second sub-divider
    //------------------------------------------------------------------

    assign stage1.in_tick    = pre_tick; // [R15]
    assign stage1.in_level   = pre_level;
    assign stage1.low_cnt    = sub1_counts[clkdiv_pkg::LOW_MSB:clkdiv_pkg::LOW_LSB]; // [R3]
    assign stage1.high_cnt   = sub1_counts[clkdiv_pkg::HIGH_MSB:clkdiv_pkg::HIGH_LSB]; // [R3]
    assign stage1.bypass     = bypass1; // [R5]
    assign stage1.start_high = start1; // [R9]
    assign stage1.hold       = sync_active; // [R6]

    assign stage2.in_tick    = stage1.out_tick; // [R15]
    assign stage2.in_level   = stage1.out_level;
    assign stage2.low_cnt    = sub2_counts[clkdiv_pkg::LOW_MSB:clkdiv_pkg::LOW_LSB]; // [R1]
    assign stage2.high_cnt   = sub2_counts[clkdiv_pkg::HIGH_MSB:clkdiv_pkg::HIGH_LSB]; // [R2]
    assign stage2.bypass     = bypass2; // [R4]
    assign stage2.start_high = start2; // [R8]
    assign stage2.hold       = sync_active; // [R6]

    subdiv u_sub1 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .s     (stage1.div)
    );

    subdiv u_sub2 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .s     (stage2.div)
    );

    assign sub1_clk_o = stage1.out_level;

    //------------------------------------------------------------------
    // Duty-cycle correction
    // Measures the cascade period in clk cycles between rising edges and
    // regenerates a half-high waveform. Costs one full period of settling
    // after any ratio change or alignment release.
    //------------------------------------------------------------------

    assign duty_on     = !duty_fix_disable && period_valid; // [R10] [R11]
    assign half_period = (period + {{(PERIOD_W-1){1'b0}}, 1'b1}) >> 1;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            per_cnt <= '0;
        end else if (sync_active || stage2.out_tick) begin
            per_cnt <= '0;
        end else if (per_cnt != '1) begin
            per_cnt <= per_cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
        end
    end

    // Period of zero or one cannot be corrected, so it is never marked valid
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            period       <= '0;
            period_valid <= 1'b0;
        end else if (sync_active || pre_static) begin
            period       <= '0;
            period_valid <= 1'b0;
        end else if (stage2.out_tick) begin
            period       <= per_cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
            period_valid <= (per_cnt != '0) && (per_cnt != '1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            duty_level <= 1'b0;
        end else if (stage2.out_tick) begin
            duty_level <= 1'b1;
        end else begin
            duty_level <= (per_cnt + {{(PERIOD_W-1){1'b0}}, 1'b1}) < half_period;
        end
    end

    //------------------------------------------------------------------
    // Channel output
    //------------------------------------------------------------------

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            chan_clk_o <= 1'b0;
        end else if (nosync) begin
            chan_clk_o <= force_high; // [R7]
        end else if (sync_active) begin
            chan_clk_o <= start2; // [R6] [R8]
        end else if (duty_on) begin
            chan_clk_o <= duty_level; // [R10]
        end else begin
            chan_clk_o <= stage2.out_level; // [R11]
        end
    end

    //------------------------------------------------------------------
    // Read path: data stand one cycle after the read strobe
    //------------------------------------------------------------------

    always_comb begin
        status                          = clkdiv_pkg::READ_ZERO;
        status[clkdiv_pkg::ST_CHAN]     = chan_clk_o;
        status[clkdiv_pkg::ST_SYNC]     = sync_active;
        status[clkdiv_pkg::ST_PRE_STAT] = pre_static;
        status[clkdiv_pkg::ST_DUTY_ON]  = duty_on;
        status[clkdiv_pkg::ST_SUB1]     = stage1.out_level;
        status[clkdiv_pkg::ST_PRE]      = pre_level;
    end

    always_comb begin
        next_rdata = clkdiv_pkg::READ_ZERO;
        unique case (addr_i)
            clkdiv_pkg::ADDR_SUB2_COUNTS: next_rdata = sub2_counts;
            clkdiv_pkg::ADDR_CTRL:        next_rdata = ctrl;
            clkdiv_pkg::ADDR_DUTY:        next_rdata = duty;
            clkdiv_pkg::ADDR_STATUS:      next_rdata = status;
            clkdiv_pkg::ADDR_SUB1_COUNTS: next_rdata = sub1_counts;
            clkdiv_pkg::ADDR_PERIOD_LO:   next_rdata = period[7:0];
            clkdiv_pkg::ADDR_PERIOD_HI:   next_rdata = 8'(period[PERIOD_W-1:8]);
            clkdiv_pkg::ADDR_PRESCALE:    next_rdata = prescale;
            default:                      next_rdata = clkdiv_pkg::READ_ZERO;
        endcase
    end

    // Holds zero outside the answer cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= clkdiv_pkg::READ_ZERO;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= clkdiv_pkg::READ_ZERO;
        end
    end

endmodule // channel_clock_divider_pair

// File: verilog/clkdiv_pkg.sv
// Package: register map, field layout and encodings of the channel divider pair
//
// Notes on behaviour
// R1: The second sub-divider stays low for its low-count field plus one input cycles.
// R2: The second sub-divider stays high for its high-count field plus one input cycles.
// R3: The first sub-divider counts low and high time the same way from its own two fields.
// R4: Setting the second bypass bit stops that divider and passes its input straight through.
// R5: Setting the first bypass bit stops that divider and passes its input straight through.
// R6: With the sync-ignore bit clear the dividers obey the alignment signal, set they ignore it.
// R7: The force-level bit sets the static channel level, and acts only while sync-ignore is set.
// R8: The second sub-divider starts low when its start bit is zero and high when it is one.
// R9: The first sub-divider starts low when its start bit is zero and high when it is one.
// R10: Duty-cycle correction is applied while the correction-disable bit is zero.
// R11: Setting the correction-disable bit turns duty-cycle correction off.
// R12: Prescaler codes 000 to 100 divide by 2, 3, 4, 5 and 6, with divide by 4 at reset.
// R13: Prescaler codes 101 and 110 stop the prescaler and hold its output static.
// R14: Software picks a static prescaler code only after oscillator calibration is done.
// R15: The prescaler feeds the first sub-divider, which feeds the second in cascade.
package clkdiv_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_SUB2_COUNTS = 10'h1a0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL        = 10'h1a1;
    localparam logic [ADDR_W-1:0] ADDR_DUTY        = 10'h1a2;
    localparam logic [ADDR_W-1:0] ADDR_STATUS      = 10'h1a3;
    localparam logic [ADDR_W-1:0] ADDR_SUB1_COUNTS = 10'h1a4;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD_LO   = 10'h1a5;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD_HI   = 10'h1a6;
    localparam logic [ADDR_W-1:0] ADDR_PRESCALE    = 10'h1e0;

    // Field positions
    localparam int LOW_MSB      = 7;
    localparam int LOW_LSB      = 4;
    localparam int HIGH_MSB     = 3;
    localparam int HIGH_LSB     = 0;
    localparam int BIT_BYPASS2  = 5;
    localparam int BIT_BYPASS1  = 4;
    localparam int BIT_NOSYNC   = 3;
    localparam int BIT_FORCE    = 2;
    localparam int BIT_START2   = 1;
    localparam int BIT_START1   = 0;
    localparam int BIT_DUTY_OFF = 0;
    localparam int PRE_MSB      = 2;
    localparam int ST_CHAN      = 0;
    localparam int ST_SYNC      = 1;
    localparam int ST_PRE_STAT  = 2;
    localparam int ST_DUTY_ON   = 3;
    localparam int ST_SUB1      = 4;
    localparam int ST_PRE       = 5;

    // Reset values
    localparam logic [DATA_W-1:0] RST_COUNTS   = 8'h00;
    localparam logic [DATA_W-1:0] RST_CTRL     = 8'h00;
    localparam logic [DATA_W-1:0] RST_DUTY     = 8'h00;
    localparam logic [DATA_W-1:0] RST_PRESCALE = 8'h02;
    localparam logic [DATA_W-1:0] READ_ZERO    = 8'h00;

    // Prescaler ratio codes
    localparam logic [2:0] PRE_DIV2    = 3'h0;
    localparam logic [2:0] PRE_DIV6    = 3'h4;
    localparam logic [2:0] PRE_STATIC0 = 3'h5;
    localparam logic [2:0] PRE_STATIC1 = 3'h6;
    localparam logic [3:0] PRE_BASE    = 4'h2;

    typedef enum logic [1:0] {
        PH_LOW  = 2'b01,
        PH_HIGH = 2'b10
    } phase_t;

endpackage

// File: verilog/subdiv_if.sv
// Interface: one sub-divider stage, parent side and divider side
`timescale 1ns/10ps
interface subdiv_if;
    logic       in_tick;
    logic       in_level;
    logic [3:0] low_cnt;
    logic [3:0] high_cnt;
    logic       bypass;
    logic       start_high;
    logic       hold;
    logic       out_tick;
    logic       out_level;

    modport parent (output in_tick, in_level, low_cnt, high_cnt, bypass, start_high, hold,
                    input  out_tick, out_level);
    modport div    (input  in_tick, in_level, low_cnt, high_cnt, bypass, start_high, hold,
                    output out_tick, out_level);
endinterface

// File: verilog/subdiv.sv
// Module: one sub-divider with low/high counts, start polarity and bypass
`timescale 1ns/10ps
module subdiv (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Stage link
    subdiv_if.div     s
);

    clkdiv_pkg::phase_t phase;
    logic [3:0]         cnt;
    logic               level;
    logic               last_cycle;
    logic [3:0]         limit;

    assign limit      = (phase == clkdiv_pkg::PH_HIGH) ? s.high_cnt : s.low_cnt;
    assign last_cycle = s.in_tick && (cnt == limit);

    // Phase and cycle count; bypass keeps the counter parked (powered down)
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase <= clkdiv_pkg::PH_LOW;
            cnt   <= 4'h0;
        end else if (s.hold || s.bypass) begin // [R4] [R5]
            phase <= s.start_high ? clkdiv_pkg::PH_HIGH : clkdiv_pkg::PH_LOW; // [R8] [R9]
            cnt   <= 4'h0;
        end else if (last_cycle) begin // [R1] [R2] [R3]
            cnt <= 4'h0;
            unique case (phase)
                clkdiv_pkg::PH_LOW:  phase <= clkdiv_pkg::PH_HIGH;
                clkdiv_pkg::PH_HIGH: phase <= clkdiv_pkg::PH_LOW;
                default:             phase <= clkdiv_pkg::PH_LOW;
            endcase
        end else if (s.in_tick) begin
            cnt <= cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            level <= 1'b0;
        end else begin
            level <= (phase == clkdiv_pkg::PH_HIGH);
        end
    end

    // Rising edge of this stage is one input cycle of the next
    assign s.out_tick  = s.bypass ? s.in_tick : (last_cycle && phase == clkdiv_pkg::PH_LOW);
    assign s.out_level = s.bypass ? s.in_level : level; // [R4] [R5]

endmodule // subdiv

// File: verification/channel_clock_divider_pair_asserts.sv
// Checker: port-level properties of the channel divider pair
`timescale 1ns/10ps
module channel_clock_divider_pair_asserts #(
    parameter int PERIOD_W = 14
) (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Register port
    input  wire logic [clkdiv_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [clkdiv_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    input  wire logic [clkdiv_pkg::DATA_W-1:0] rdata_o,
    // Alignment and clock levels
    input  wire logic                          sync_i,
    input  wire logic                          pre_clk_o,
    input  wire logic                          sub1_clk_o,
    input  wire logic                          chan_clk_o
);
    localparam int SETTLE = 200;
    logic [2:0] code;
    logic [5:0] ctrl;
    logic [3:0] hi1;
    logic [3:0] lo1;
    logic [9:0] quiet;
    logic [9:0] pre_gap;
    logic [9:0] s1_hi;
    logic       unmapped;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            code <= 3'h2;
            ctrl <= 6'h00;
            {lo1, hi1} <= 8'h00;
        end else if (wr_i) begin
            if (addr_i == clkdiv_pkg::ADDR_PRESCALE)
                code <= wdata_i[2:0];
            if (addr_i == clkdiv_pkg::ADDR_CTRL)
                ctrl <= wdata_i[5:0];
            if (addr_i == clkdiv_pkg::ADDR_SUB1_COUNTS)
                {lo1, hi1} <= wdata_i;
        end
    end

    // Waveforms are judged only once writes and alignment holds have died out
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            quiet <= 10'h000;
        else if (wr_i || (sync_i && !ctrl[3]))
            quiet <= 10'h000;
        else if (quiet != 10'h3ff)
            quiet <= quiet + 10'h001;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_gap <= 10'h000;
            s1_hi   <= 10'h000;
        end else begin
            pre_gap <= $rose(pre_clk_o) ? 10'h001 : pre_gap + 10'h001;
            s1_hi   <= sub1_clk_o ? s1_hi + 10'h001 : 10'h000;
        end
    end

    assign unmapped = !(addr_i inside {[clkdiv_pkg::ADDR_SUB2_COUNTS:clkdiv_pkg::ADDR_PERIOD_HI],
                                       clkdiv_pkg::ADDR_PRESCALE});

    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not zero outside read slot");
    unmapped_read_a: assert property ($past(rd_i && unmapped) |-> rdata_o == 8'h00)
        else $error("unmapped read returned data");
    pre_read_a: assert property (
        $past(rd_i && addr_i == clkdiv_pkg::ADDR_PRESCALE) |-> rdata_o == {5'h00, $past(code)})
        else $error("prescaler readback wrong");
    pre_period_a: assert property (
        $rose(pre_clk_o) && quiet > SETTLE && code < 3'h5 |-> pre_gap == 10'(code) + 10'd2)
        else $error("prescaler period wrong");
    static_pre_a: assert property (code >= 3'h5 && quiet > 8 |-> !pre_clk_o)
        else $error("static prescaler output not low");
    sub1_freeze_a: assert property (code >= 3'h5 && quiet > 8 |-> $stable(sub1_clk_o))
        else $error("first stage moved with prescaler stopped");
    sub1_high_a: assert property (
        $fell(sub1_clk_o) && quiet > SETTLE && code < 3'h5 && !ctrl[4]
        |-> s1_hi == (10'(code) + 10'd2) * (10'(hi1) + 10'd1))
        else $error("first stage high time wrong");
    sync_hold2_a: assert property ((sync_i && !ctrl[3])[*8] |-> chan_clk_o == ctrl[1])
        else $error("channel not held at start level");
    sync_hold1_a: assert property (
        (sync_i && !ctrl[3] && !ctrl[4])[*8] |-> sub1_clk_o == ctrl[0])
        else $error("first stage not held at start level");
    force_level_a: assert property (ctrl[3] && quiet > 8 |-> chan_clk_o == ctrl[2])
        else $error("forced channel level wrong");
endmodule // channel_clock_divider_pair_asserts

bind channel_clock_divider_pair channel_clock_divider_pair_asserts #(.PERIOD_W(PERIOD_W)) chk_u (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .addr_i     (addr_i),
    .wdata_i    (wdata_i),
    .wr_i       (wr_i),
    .rd_i       (rd_i),
    .rdata_o    (rdata_o),
    .sync_i     (sync_i),
    .pre_clk_o  (pre_clk_o),
    .sub1_clk_o (sub1_clk_o),
    .chan_clk_o (chan_clk_o)
);

// File: verification/channel_clock_divider_pair_tb.sv
// Testbench: register access and waveform checks of the channel divider pair
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %0t got %0h exp %0h", $time, (got), (exp)); end end
module channel_clock_divider_pair_tb;
    localparam int SETTLE = 300;
    logic                          clk_i;
    logic                          rst_i;
    logic [clkdiv_pkg::ADDR_W-1:0] addr_i;
    logic [clkdiv_pkg::DATA_W-1:0] wdata_i;
    logic                          wr_i;
    logic                          rd_i;
    logic [clkdiv_pkg::DATA_W-1:0] rdata_o;
    logic                          sync_i;
    logic                          pre_clk_o;
    logic                          sub1_clk_o;
    logic                          chan_clk_o;
    logic                          lvl;
    int                            errors;
    int                            n_checks;
    int                            hi;
    int                            lo;
    int                            flips;

    channel_clock_divider_pair #(.PERIOD_W(14)) dut_u (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .addr_i     (addr_i),
        .wdata_i    (wdata_i),
        .wr_i       (wr_i),
        .rd_i       (rd_i),
        .rdata_o    (rdata_o),
        .sync_i     (sync_i),
        .pre_clk_o  (pre_clk_o),
        .sub1_clk_o (sub1_clk_o),
        .chan_clk_o (chan_clk_o)
    );

    initial clk_i = 1'b0;
    always #5 clk_i = ~clk_i;

    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic chk_reg(input logic [9:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        @(negedge clk_i);
        `CHK(rdata_o, e)
    endtask

    function automatic logic pick(input int sel);
        return (sel == 0) ? pre_clk_o : (sel == 1) ? sub1_clk_o : chan_clk_o;
    endfunction

    // Bounded so that a dead output shows up as zero lengths, not a hang
    task automatic meas(input int sel);
        int n;
        n  = 0;
        hi = 0;
        lo = 0;
        @(negedge clk_i);
        while (pick(sel) !== 1'b0 && n < 3000) begin @(negedge clk_i); n++; end
        while (pick(sel) !== 1'b1 && n < 3000) begin @(negedge clk_i); n++; end
        while (pick(sel) === 1'b1 && n < 3000) begin @(negedge clk_i); n++; hi++; end
        while (pick(sel) === 1'b0 && n < 3000) begin @(negedge clk_i); n++; lo++; end
    endtask

    task automatic chk_wave(input int sel, input int eh, input int el);
        repeat (SETTLE) @(posedge clk_i);
        meas(sel);
        `CHK(hi, eh)
        `CHK(lo, el)
    endtask

    task automatic set_sync(input logic v);
        @(posedge clk_i);
        sync_i <= v;
        repeat (12) @(negedge clk_i);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge clk_i);
        errors++;
        $display("BAD %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        {addr_i, wdata_i, wr_i, rd_i, sync_i} = '0;
        errors   = 0;
        n_checks = 0;
        rst_i    = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_reg(clkdiv_pkg::ADDR_SUB2_COUNTS, 8'h00);
        chk_reg(clkdiv_pkg::ADDR_CTRL, 8'h00);
        chk_reg(clkdiv_pkg::ADDR_DUTY, 8'h00);
        chk_reg(clkdiv_pkg::ADDR_PRESCALE, 8'h02);
        wr_reg(10'h3ff, 8'hff);
        chk_reg(10'h3ff, 8'h00);
        wr_reg(clkdiv_pkg::ADDR_CTRL, 8'hff);
        chk_reg(clkdiv_pkg::ADDR_CTRL, 8'h3f);
        wr_reg(clkdiv_pkg::ADDR_SUB2_COUNTS, 8'ha5);
        chk_reg(clkdiv_pkg::ADDR_SUB2_COUNTS, 8'ha5);
        wr_reg(clkdiv_pkg::ADDR_CTRL, 8'h00);
        $display("test registers done");
        wr_reg(clkdiv_pkg::ADDR_SUB1_COUNTS, 8'h10);
        for (int c = 0; c <= 4; c++) begin
            wr_reg(clkdiv_pkg::ADDR_PRESCALE, 8'(c));
            chk_wave(1, c + 2, 2 * (c + 2));
            meas(0);
            `CHK(hi + lo, c + 2)
        end
        $display("test prescaler done");
        wr_reg(clkdiv_pkg::ADDR_DUTY, 8'h01);
        for (int c = 5; c <= 6; c++) begin
            wr_reg(clkdiv_pkg::ADDR_PRESCALE, 8'(c));
            repeat (20) @(negedge clk_i);
            lvl   = sub1_clk_o;
            flips = 0;
            repeat (60) begin
                @(negedge clk_i);
                if (pre_clk_o !== 1'b0 || sub1_clk_o !== lvl) flips++;
            end
            `CHK(flips, 0)
        end
        $display("test static done");
        wr_reg(clkdiv_pkg::ADDR_PRESCALE, 8'h00);
        wr_reg(clkdiv_pkg::ADDR_SUB2_COUNTS, 8'h02);
        chk_wave(2, 18, 6);
        wr_reg(clkdiv_pkg::ADDR_DUTY, 8'h00);
        chk_wave(2, 12, 12);
        chk_reg(clkdiv_pkg::ADDR_PERIOD_LO, 8'h18);
        chk_reg(clkdiv_pkg::ADDR_PERIOD_HI, 8'h00);
        wr_reg(clkdiv_pkg::ADDR_DUTY, 8'h01);
        $display("test channel done");
        wr_reg(clkdiv_pkg::ADDR_CTRL, 8'h20);
        chk_wave(2, 2, 4);
        wr_reg(clkdiv_pkg::ADDR_CTRL, 8'h10);
        chk_wave(1, 1, 1);
        chk_wave(2, 6, 2);
        $display("test bypass done");
        for (int s = 0; s <= 3; s++) begin
            wr_reg(clkdiv_pkg::ADDR_CTRL, 8'(s));
            set_sync(1'b1);
            `CHK(sub1_clk_o, s[0])
            `CHK(chan_clk_o, s[1])
            set_sync(1'b0);
        end
        wr_reg(clkdiv_pkg::ADDR_CTRL, 8'h00);
        chk_wave(2, 18, 6);
        $display("test sync done");
        // Alignment held on while the channel must ignore it
        wr_reg(clkdiv_pkg::ADDR_CTRL, 8'h08);
        set_sync(1'b1);
        `CHK(chan_clk_o, 1'b0)
        chk_wave(1, 2, 4);
        wr_reg(clkdiv_pkg::ADDR_CTRL, 8'h0c);
        repeat (8) @(negedge clk_i);
        `CHK(chan_clk_o, 1'b1)
        set_sync(1'b0);
        wr_reg(clkdiv_pkg::ADDR_CTRL, 8'h04);
        chk_wave(2, 18, 6);
        $display("test force done");
        wrap_up();
    end
endmodule // channel_clock_divider_pair_tb
